// ===== hdl/adm_core.sv
// Purpose: Instruction sequencer with operand addressing of an 8-bit core.
// Assumes: Memory returns read data in the same cycle as the request shows.
// Notes: Stacking, returns, interrupts and low-power control are not modelled.
//
// What this block does
// - Decode a 62-operation set, each reached through one of eight modes.
// - No-operand forms are one byte, fetch no address, touch registers only.
// - Literal forms are two bytes; the literal meets A or X directly.
// - Page-zero forms are two bytes; high address byte is forced to zero.
// - Full-address forms are three bytes, high address byte first.
// - Pointer form without displacement is one byte; address is zero-extended X.
// - Short-displacement form is two bytes; address is X plus byte, unsigned.
// - Long-displacement form is three bytes; X plus 16-bit displacement, high first.
// - Branches add a signed byte to next-instruction address when condition holds.
// - Register/memory operations combine A or X with one memory operand.
// - Modify-in-place operations read, alter and write back the same location.
// - Single-bit set and clear accept page-zero addressing only.
// - Negative-or-zero test reads and evaluates but never writes back.
// - Jumps use no register operand; failed branches fall through sequentially.
// - Bit-test branches are three bytes: opcode, page-zero address, displacement.
// - Bit-test branches copy the tested bit into carry, taken or not.
// - Program counter keeps eleven bits; upper five read as zero.
// - Additions set half-carry on a carry from bit 3 into bit 4.
`timescale 1ns/1ps
`default_nettype none
module adm_core #(
  parameter logic [adm_pkg::ADDR_W-1:0] RST_PC = adm_pkg::RESET_PC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic irq_n_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] acc_o,
  output logic [7:0] idx_o,
  output logic [7:0] ccr_o,
  output logic [15:0] pc_o,
  output adm_pkg::adm_mode_t mode_o
);
  import adm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adm_state_t state_r, state_nxt;
  adm_mode_t mode_r;
  logic [ADDR_W-1:0] pc_r, pc_nxt, addr_r, addr_nxt;
  logic [7:0] a_r, a_nxt, x_r, x_nxt, op_r, op_nxt, b1_r, b1_nxt, b2_r, b2_nxt;
  logic [7:0] opnd_r, opnd_nxt, wdata_r, wdata_nxt;
  logic h_r, h_nxt, i_r, i_nxt, n_r, n_nxt, z_r, z_nxt, c_r, c_nxt;
  logic rd_r, rd_nxt, wr_r, wr_nxt;
  logic irq_meta_r, irq_sync_r;

  adm_dp_if dp ();
  adm_agu u_agu (.dp(dp));
  adm_alu u_alu (.dp(dp));

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic adm_mode_t mode_of(input logic [3:0] h);
    case (h)
      HN_BTB, HN_BSC, HN_RMWD, 4'hB: mode_of = M_DIR;
      HN_REL: mode_of = M_REL;
      4'h6, 4'hE: mode_of = M_IX1;
      HN_RMWI, 4'hF: mode_of = M_IX;
      HN_IMM: mode_of = M_IMM;
      4'hC: mode_of = M_EXT;
      4'hD: mode_of = M_IX2;
      default: mode_of = M_INH;
    endcase
  endfunction

  logic [3:0] hn, ln;
  adm_mode_t mode;
  logic is_btb, is_bsc, is_rel, is_mul, is_rmw, is_hi, is_jmp, is_regmem, is_store;
  logic is_tst, rmw_a, rmw_x, uses_x, mem_mode, needs_rd, needs_wr, wr_a, wr_x;
  logic [1:0] nbytes;
  logic [2:0] bit_n;
  logic [7:0] bit_mask, bsc_res;
  logic [15:0] prod;
  logic bit_val, btb_take, br_base, br_take;

  assign hn = op_r[7:4];
  assign ln = op_r[3:0];
  assign mode = mode_of(hn);
  assign is_btb = (hn == HN_BTB);
  assign is_bsc = (hn == HN_BSC);
  assign is_rel = (hn == HN_REL);
  assign is_mul = (op_r == OP_MULT);
  assign is_rmw = (hn >= HN_RMWD) && (hn <= HN_RMWI) && !is_mul;
  assign is_hi = (hn >= HN_IMM);
  assign is_jmp = is_hi && ((ln == LN_JUMP) || (ln == LN_CALL));
  assign is_regmem = is_hi && !is_jmp;
  assign is_store = is_regmem && ((ln == LN_ASTORE) || (ln == LN_XSTORE));
  assign is_tst = is_rmw && (ln == LN_TEST);
  assign rmw_a = is_rmw && (hn == HN_RMWA);
  assign rmw_x = is_rmw && (hn == HN_RMWX);
  assign uses_x = is_regmem && ((ln == LN_XCOMP) || (ln == LN_XLOAD) || (ln == LN_XSTORE));
  assign mem_mode = (mode == M_DIR) || (mode == M_EXT) || (mode == M_IX) ||
                    (mode == M_IX1) || (mode == M_IX2);
  assign needs_rd = mem_mode && !is_store && !is_jmp;
  assign needs_wr = is_store || is_bsc || (is_rmw && !rmw_a && !rmw_x && !is_tst);
  assign nbytes = (is_btb || (mode == M_EXT) || (mode == M_IX2)) ? 2'd2 :
                  ((mode == M_INH) || (mode == M_IX)) ? 2'd0 : 2'd1;
  assign wr_a = (is_regmem && !uses_x && (ln != LN_ACOMP) && (ln != LN_BITT) &&
                 (ln != LN_ASTORE)) || (rmw_a && !is_tst);
  assign wr_x = (is_regmem && (ln == LN_XLOAD)) || (rmw_x && !is_tst);

  assign bit_n = op_r[BITN_MSB:BITN_LSB];
  assign bit_mask = 8'h01 << bit_n;
  assign bit_val = opnd_r[bit_n];
  assign btb_take = bit_val ^ op_r[OPB_POL];
  assign bsc_res = op_r[OPB_POL] ? (opnd_r & ~bit_mask) : (opnd_r | bit_mask);
  assign prod = {8'h00, x_r} * {8'h00, a_r};

  // The branch rows come in pairs: odd rows test the opposite sense.
  always_comb begin
    unique case (ln[3:1])
      3'h0: br_base = 1'b1;
      3'h1: br_base = !(c_r | z_r);
      3'h2: br_base = !c_r;
      3'h3: br_base = !z_r;
      3'h4: br_base = !h_r;
      3'h5: br_base = !n_r;
      3'h6: br_base = !i_r;
      3'h7: br_base = !irq_sync_r;
    endcase
  end
  assign br_take = br_base ^ ln[0];

  assign dp.rmw = is_rmw;
  assign dp.ln = ln;
  assign dp.cin = c_r;
  assign dp.opd_a = uses_x ? x_r : a_r;
  assign dp.opd_m = rmw_a ? a_r : rmw_x ? x_r : (mode == M_IMM) ? b1_r : opnd_r;
  assign dp.mode = mode;
  assign dp.x = x_r;
  assign dp.b1 = b1_r;
  assign dp.b2 = b2_r;
  assign dp.rel = is_btb ? b2_r : b1_r;
  assign dp.pc = pc_r;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    addr_nxt = addr_r;
    a_nxt = a_r;
    x_nxt = x_r;
    op_nxt = op_r;
    b1_nxt = b1_r;
    b2_nxt = b2_r;
    opnd_nxt = opnd_r;
    wdata_nxt = wdata_r;
    h_nxt = h_r;
    i_nxt = i_r;
    n_nxt = n_r;
    z_nxt = z_r;
    c_nxt = c_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    unique case (state_r)
      S_FETCH: begin
        addr_nxt = pc_r;
        rd_nxt = 1'b1;
        pc_nxt = pc_r + 11'h001;
        state_nxt = S_OPC;
      end
      S_OPC: begin
        op_nxt = mem_rdata_i;
        state_nxt = S_DEC;
      end
      S_DEC: begin
        if (nbytes != 2'd0) begin
          addr_nxt = pc_r;
          rd_nxt = 1'b1;
          pc_nxt = pc_r + 11'h001;
          state_nxt = S_B1;
        end else if (needs_rd) begin
          addr_nxt = dp.ea;
          rd_nxt = 1'b1;
          state_nxt = S_ADR;
        end else begin
          state_nxt = S_EXEC;
        end
      end
      S_B1: begin
        b1_nxt = mem_rdata_i;
        if (nbytes == 2'd2) begin
          addr_nxt = pc_r;
          rd_nxt = 1'b1;
          pc_nxt = pc_r + 11'h001;
          state_nxt = S_B2;
        end else begin
          state_nxt = S_ADR;
        end
      end
      S_B2: begin
        b2_nxt = mem_rdata_i;
        state_nxt = S_ADR;
      end
      S_ADR: begin
        // Entered straight from decode when X alone forms the address;
        // then the operand is already on the bus and is captured here.
        if (rd_r && (addr_r == dp.ea) && (nbytes == 2'd0)) begin
          opnd_nxt = mem_rdata_i;
          state_nxt = S_EXEC;
        end else if (needs_rd) begin
          addr_nxt = dp.ea;
          rd_nxt = 1'b1;
          state_nxt = S_OPC;
          op_nxt = op_r;
        end else begin
          state_nxt = S_EXEC;
        end
      end
      S_EXEC: begin
        state_nxt = S_FETCH;
        if (needs_wr) begin
          addr_nxt = dp.ea;
          wr_nxt = 1'b1;
          wdata_nxt = is_bsc ? bsc_res : dp.res;
        end
        if (is_regmem || is_rmw) begin
          n_nxt = dp.fn;
          z_nxt = dp.fz;
          if (dp.cw) c_nxt = dp.fc;
          if (dp.hw) h_nxt = dp.fh;
        end
        if (wr_a) a_nxt = dp.res;
        if (wr_x) x_nxt = dp.res;
        if (is_mul) begin
          x_nxt = prod[15:8];
          a_nxt = prod[7:0];
          h_nxt = 1'b0;
          c_nxt = 1'b0;
        end
        if (is_btb) begin
          c_nxt = bit_val;
          if (btb_take) pc_nxt = dp.tgt;
        end
        if (is_rel && br_take) pc_nxt = dp.tgt;
        if (is_jmp) pc_nxt = dp.ea;
        case (op_r)
          OP_A2X: x_nxt = a_r;
          OP_X2A: a_nxt = x_r;
          OP_CLRC: c_nxt = 1'b0;
          OP_SETC: c_nxt = 1'b1;
          OP_CLRI: i_nxt = 1'b0;
          OP_SETI: i_nxt = 1'b1;
          default: ;
        endcase
      end
    endcase
  end

  logic opnd_phase_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) opnd_phase_r <= 1'b0;
    else if (ce_i) opnd_phase_r <= (state_r == S_ADR) && needs_rd && (state_nxt == S_OPC);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  adm_state_t state_fix;
  assign state_fix = (opnd_phase_r && (state_r == S_OPC)) ? S_EXEC : state_nxt;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= S_FETCH;
      pc_r <= RST_PC;
      mode_r <= M_INH;
    end else if (ce_i) begin
      state_r <= state_fix;
      pc_r <= pc_nxt;
      if (state_r == S_DEC) mode_r <= mode;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      op_r <= 8'h00;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      opnd_r <= 8'h00;
    end else if (ce_i) begin
      op_r <= opnd_phase_r ? op_r : op_nxt;
      b1_r <= b1_nxt;
      b2_r <= b2_nxt;
      opnd_r <= opnd_phase_r ? mem_rdata_i : opnd_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      a_r <= 8'h00;
      x_r <= 8'h00;
      {h_r, i_r, n_r, z_r, c_r} <= 5'h08;
    end else if (ce_i) begin
      a_r <= a_nxt;
      x_r <= x_nxt;
      {h_r, i_r, n_r, z_r, c_r} <= {h_nxt, i_nxt, n_nxt, z_nxt, c_nxt};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      addr_r <= '0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= 8'h00;
    end else if (ce_i) begin
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // The pin is asynchronous to the core clock; two stages before use.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_meta_r <= 1'b1;
      irq_sync_r <= 1'b1;
    end else if (ce_i) begin
      irq_meta_r <= irq_n_i;
      irq_sync_r <= irq_meta_r;
    end
  end

  assign mem_addr_o = {{PAD_W{1'b0}}, addr_r};
  assign mem_rd_o = rd_r;
  assign mem_wr_o = wr_r;
  assign mem_wdata_o = wdata_r;
  assign acc_o = a_r;
  assign idx_o = x_r;
  assign ccr_o = {CCR_FIXED, h_r, i_r, n_r, z_r, c_r};
  assign pc_o = {{PAD_W{1'b0}}, pc_r};
  assign mode_o = mode_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  logic [15:0] ix1_chk, ext_chk;
  logic [ADDR_W-1:0] ext_lo, rel_chk;
  logic [4:0] hsum_chk;
  assign ix1_chk = {8'h00, x_r} + {8'h00, b1_r};
  assign ext_chk = {b1_r, b2_r};
  assign ext_lo = ext_chk[ADDR_W-1:0];
  assign rel_chk = pc_r + {{(ADDR_W - 8){b1_r[7]}}, b1_r};
  assign hsum_chk = {1'b0, a_r[3:0]} + {1'b0, dp.opd_m[3:0]} + {4'h0, c_r & (ln == LN_ADDC)};

  // Only the forms that issue their operand read from the address step; the
  // pointer form without displacement has already read it during decode.
  sequence s_rmw_read;
    state_r == S_ADR && is_rmw && !is_tst && needs_rd && (nbytes != 2'd0) && ce_i;
  endsequence
  sequence s_rmw_eval;
    ce_i [*2];
  endsequence

  property p_inh_len;
    state_r == S_DEC && mode == M_INH && ce_i |=> pc_r == $past(pc_r) && !mem_rd_o;
  endproperty
  a_inh_len: assert property (p_inh_len) else $error("no-operand form fetched a byte");
  property p_imm_noread;
    state_r == S_ADR && mode == M_IMM && ce_i |=> state_r == S_EXEC && !mem_rd_o;
  endproperty
  a_imm_noread: assert property (p_imm_noread) else $error("literal form read memory");
  property p_dir_addr;
    state_r == S_ADR && mode == M_DIR && needs_rd && ce_i |=>
      mem_rd_o && mem_addr_o == {PAGE0_HI, $past(b1_r)};
  endproperty
  a_dir_addr: assert property (p_dir_addr) else $error("page-zero address wrong");
  property p_ext_addr;
    state_r == S_ADR && mode == M_EXT && needs_rd && ce_i |=>
      mem_addr_o[ADDR_W-1:0] == $past(ext_lo) && mem_addr_o[15:ADDR_W] == '0;
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("full address wrong");
  property p_ix_addr;
    state_r == S_DEC && mode == M_IX && needs_rd && ce_i |=>
      mem_rd_o && mem_addr_o == {PAGE0_HI, $past(x_r)};
  endproperty
  a_ix_addr: assert property (p_ix_addr) else $error("pointer address wrong");
  property p_ix1_addr;
    state_r == S_ADR && mode == M_IX1 && needs_rd && ce_i |=> mem_addr_o == $past(ix1_chk);
  endproperty
  a_ix1_addr: assert property (p_ix1_addr) else $error("short displacement sum wrong");
  property p_rel_pc;
    state_r == S_EXEC && is_rel && ce_i |=>
      pc_r == ($past(br_take) ? $past(rel_chk) : $past(pc_r));
  endproperty
  a_rel_pc: assert property (p_rel_pc) else $error("branch destination wrong");
  property p_rmw_wb;
    s_rmw_read ##1 s_rmw_eval |=> mem_wr_o && mem_addr_o == $past(mem_addr_o, 2);
  endproperty
  a_rmw_wb: assert property (p_rmw_wb) else $error("modify-in-place write-back missing");
  property p_bsc_dir;
    state_r == S_EXEC && is_bsc && ce_i |=>
      mem_wr_o && mem_addr_o == {PAGE0_HI, $past(b1_r)};
  endproperty
  a_bsc_dir: assert property (p_bsc_dir) else $error("bit set or clear not page zero");
  property p_tst_nowr;
    state_r == S_EXEC && is_tst && ce_i |=> !mem_wr_o;
  endproperty
  a_tst_nowr: assert property (p_tst_nowr) else $error("test wrote back");
  property p_btb_carry;
    state_r == S_EXEC && is_btb && ce_i |=> c_r == $past(bit_val);
  endproperty
  a_btb_carry: assert property (p_btb_carry) else $error("tested bit not in carry");
  property p_pc_width;
    pc_o[15:ADDR_W] == '0 && mem_addr_o[15:ADDR_W] == '0;
  endproperty
  a_pc_width: assert property (p_pc_width) else $error("upper address bits not zero");
  property p_half_carry;
    state_r == S_EXEC && is_regmem && (ln == LN_ADD || ln == LN_ADDC) && ce_i |=>
      h_r == $past(hsum_chk[4]);
  endproperty
  a_half_carry: assert property (p_half_carry) else $error("half carry wrong");
endmodule
`default_nettype wire

// ===== hdl/adm_pkg.sv
// Purpose: Shared constants and types of the addressing-mode decoder core.
// Assumes: Opcodes follow the column layout used by the core decoder.
// Notes: Address width is the implemented width of the core address space.
package adm_pkg;
  localparam int ADDR_W = 11;
  localparam int PAD_W = 16 - ADDR_W;
  localparam int OP_COUNT = 62;
  localparam logic [10:0] RESET_PC = 11'h000;
  localparam logic [7:0] PAGE0_HI = 8'h00;
  localparam logic [2:0] CCR_FIXED = 3'h7;
  localparam int OPB_POL = 0;
  localparam int BITN_LSB = 1;
  localparam int BITN_MSB = 3;
  // ----------------------------------------------------------------
  // Opcode columns and rows
  // ----------------------------------------------------------------
  localparam logic [3:0] HN_BTB = 4'h0, HN_BSC = 4'h1, HN_REL = 4'h2, HN_RMWD = 4'h3;
  localparam logic [3:0] HN_RMWA = 4'h4, HN_RMWX = 4'h5, HN_RMWI = 4'h7, HN_IMM = 4'hA;
  localparam logic [3:0] LN_SUB = 4'h0, LN_ACOMP = 4'h1, LN_SBB = 4'h2, LN_XCOMP = 4'h3;
  localparam logic [3:0] LN_AND = 4'h4, LN_BITT = 4'h5, LN_ALOAD = 4'h6, LN_ASTORE = 4'h7;
  localparam logic [3:0] LN_XOR = 4'h8, LN_ADDC = 4'h9, LN_OR = 4'hA, LN_ADD = 4'hB;
  localparam logic [3:0] LN_JUMP = 4'hC, LN_CALL = 4'hD, LN_XLOAD = 4'hE, LN_XSTORE = 4'hF;
  localparam logic [3:0] LN_NEGATE = 4'h0, LN_COMPL = 4'h3, LN_SHR = 4'h4, LN_RORC = 4'h6;
  localparam logic [3:0] LN_SHRA = 4'h7, LN_SHL = 4'h8, LN_ROLC = 4'h9, LN_DECR = 4'hA;
  localparam logic [3:0] LN_INCR = 4'hC, LN_TEST = 4'hD, LN_CLEAR = 4'hF;
  localparam logic [7:0] OP_MULT = 8'h42, OP_A2X = 8'h97, OP_CLRC = 8'h98, OP_SETC = 8'h99;
  localparam logic [7:0] OP_CLRI = 8'h9A, OP_SETI = 8'h9B, OP_X2A = 8'h9F;
  typedef enum logic [7:0] {
    M_INH = 8'h01, M_IMM = 8'h02, M_DIR = 8'h04, M_EXT = 8'h08,
    M_IX = 8'h10, M_IX1 = 8'h20, M_IX2 = 8'h40, M_REL = 8'h80
  } adm_mode_t;
  typedef enum logic [6:0] {
    S_FETCH = 7'h01, S_OPC = 7'h02, S_DEC = 7'h04, S_B1 = 7'h08,
    S_B2 = 7'h10, S_ADR = 7'h20, S_EXEC = 7'h40
  } adm_state_t;
endpackage

// ===== hdl/adm_dp_if.sv
// Purpose: Carrier between the sequencer, its address unit and its ALU.
// Assumes: All members are combinational within one clock cycle.
// Notes: The sequencer drives operands; the two leaves drive results.
`timescale 1ns/1ps
`default_nettype none
interface adm_dp_if;
  import adm_pkg::*;
  logic rmw;
  logic [3:0] ln;
  logic cin;
  logic [7:0] opd_a, opd_m, res;
  logic fn, fz, fc, fh, cw, hw;
  adm_mode_t mode;
  logic [7:0] x, b1, b2, rel;
  logic [ADDR_W-1:0] pc, ea, tgt;
  modport core(output rmw, ln, cin, opd_a, opd_m, mode, x, b1, b2, rel, pc,
               input res, fn, fz, fc, fh, cw, hw, ea, tgt);
  modport alu(input rmw, ln, cin, opd_a, opd_m, output res, fn, fz, fc, fh, cw, hw);
  modport agu(input mode, x, b1, b2, rel, pc, output ea, tgt);
endinterface
`default_nettype wire

// ===== hdl/adm_agu.sv
// Purpose: Effective operand address and branch destination.
// Assumes: Operand bytes are already captured by the sequencer.
// Notes: Operand address sums are formed at full width and only then cut to the core width.
`timescale 1ns/1ps
`default_nettype none
module adm_agu (
  adm_dp_if.agu dp
);
  import adm_pkg::*;
  logic [15:0] ext_full;
  logic [8:0] ix1_sum;
  logic [16:0] ix2_sum;
  logic [ADDR_W-1:0] rel_ext;
  assign ext_full = {dp.b1, dp.b2};
  assign ix1_sum = {1'b0, dp.x} + {1'b0, dp.b1};
  assign ix2_sum = {1'b0, ext_full} + {9'h000, dp.x};
  assign rel_ext = {{(ADDR_W - 8){dp.rel[7]}}, dp.rel};
  assign dp.tgt = dp.pc + rel_ext;
  always_comb begin
    unique case (dp.mode)
      M_DIR: dp.ea = {3'h0, dp.b1};
      M_EXT: dp.ea = ext_full[ADDR_W-1:0];
      M_IX: dp.ea = {3'h0, dp.x};
      M_IX1: dp.ea = {2'h0, ix1_sum};
      M_IX2: dp.ea = ix2_sum[ADDR_W-1:0];
      M_INH, M_IMM, M_REL: dp.ea = '0;
    endcase
  end
endmodule
`default_nettype wire

// ===== hdl/adm_alu.sv
// Purpose: Arithmetic and logic for register/memory and modify-in-place work.
// Assumes: Carry out of a subtraction means a borrow was needed.
// Notes: Flags whose write enable is low must be left alone by the caller.
`timescale 1ns/1ps
`default_nettype none
module adm_alu (
  adm_dp_if.alu dp
);
  import adm_pkg::*;
  logic cadd, csub;
  logic [8:0] sum9, dif9;
  logic [7:0] r, m, a;
  logic c, cw, hw;
  assign a = dp.opd_a;
  assign m = dp.opd_m;
  assign cadd = dp.cin & (dp.ln == LN_ADDC);
  assign csub = dp.cin & (dp.ln == LN_SBB);
  assign sum9 = {1'b0, a} + {1'b0, m} + {8'h00, cadd};
  assign dif9 = {1'b0, a} - {1'b0, m} - {8'h00, csub};
  always_comb begin
    r = m;
    c = dp.cin;
    cw = 1'b0;
    hw = 1'b0;
    if (dp.rmw) begin
      cw = 1'b1;
      case (dp.ln)
        LN_NEGATE: begin r = 8'h00 - m; c = |m; end
        LN_COMPL: begin r = ~m; c = 1'b1; end
        LN_SHR: begin r = {1'b0, m[7:1]}; c = m[0]; end
        LN_RORC: begin r = {dp.cin, m[7:1]}; c = m[0]; end
        LN_SHRA: begin r = {m[7], m[7:1]}; c = m[0]; end
        LN_SHL: begin r = {m[6:0], 1'b0}; c = m[7]; end
        LN_ROLC: begin r = {m[6:0], dp.cin}; c = m[7]; end
        LN_DECR: begin r = m - 8'h01; cw = 1'b0; end
        LN_INCR: begin r = m + 8'h01; cw = 1'b0; end
        LN_CLEAR: begin r = 8'h00; cw = 1'b0; end
        default: cw = 1'b0;
      endcase
    end else begin
      case (dp.ln)
        LN_SUB, LN_ACOMP, LN_SBB, LN_XCOMP: begin r = dif9[7:0]; c = dif9[8]; cw = 1'b1; end
        LN_AND, LN_BITT: r = a & m;
        LN_XOR: r = a ^ m;
        LN_OR: r = a | m;
        LN_ADD, LN_ADDC: begin r = sum9[7:0]; c = sum9[8]; cw = 1'b1; hw = 1'b1; end
        LN_ASTORE, LN_XSTORE: r = a;
        default: r = m;
      endcase
    end
  end
  assign dp.res = r;
  assign dp.fn = r[7];
  assign dp.fz = (r == 8'h00);
  assign dp.fc = c;
  assign dp.fh = a[4] ^ m[4] ^ sum9[4];
  assign dp.cw = cw;
  assign dp.hw = hw;
endmodule
`default_nettype wire

// ===== hdl/adm_placeholder_none.sv
`timescale 1ns/1ps

// ===== sim/adm_mem_model.sv
// Purpose: Behavioural memory on the core bus for the bench.
// Assumes: Read data shows in the same cycle as the read strobe.
// Notes: Outside reads the data lines show the inverse of the last byte read.
`timescale 1ns/1ps
`default_nettype none
module adm_mem_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:2047];
  logic [7:0] last_r = 8'h00;
  // Idle lines show the inverse of the last byte read so a core that samples late never sees a stale match.
  assign rdata_o = rd_i ? mem[addr_i[10:0]] : ~last_r;
  always @(posedge clk_i) begin
    if (wr_i) mem[addr_i[10:0]] <= wdata_i;
    if (rd_i) last_r <= rdata_o;
  end
endmodule
`default_nettype wire

// ===== sim/tb_cpu_addressing_mode_decoder.sv
// Purpose: Runs one program through every addressing mode except no-operand and checks results.
// Assumes: Program sits at 0x600 so data stores never reach it.
// Notes: Clock enable is dropped at random so that any step may be stretched.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_addressing_mode_decoder;
  import adm_pkg::*;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
  logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b0, irq_n_i = 1'b1;
  logic [7:0] rdata, wdata, acc, idx, ccr, ra, rx, b42;
  logic [15:0] addr, pc;
  logic rd, wr;
  logic [8:0] s;
  adm_mode_t mode;
  int fail_count = 0, n_compared = 0, cyc = 0;
  int tst_wr_cnt = 0;
  logic [7:0] prog [$];
  always #12.5 clk_i = ~clk_i;
  adm_core #(.RST_PC(11'h600)) uut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .irq_n_i(irq_n_i), .mem_rdata_i(rdata), .mem_addr_o(addr), .mem_rd_o(rd),
    .mem_wr_o(wr), .mem_wdata_o(wdata), .acc_o(acc), .idx_o(idx), .ccr_o(ccr),
    .pc_o(pc), .mode_o(mode));
  adm_mem_model u_mem (.clk_i(clk_i), .rd_i(rd), .wr_i(wr), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata));
  function automatic logic [10:0] ix2_ea(logic [7:0] x, logic [15:0] off);
    logic [15:0] t;
    t = off + {8'h00, x};
    return t[10:0];
  endfunction
  function automatic logic half_c(logic [7:0] a, logic [7:0] m, logic c);
    return ({1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, c}) > 5'h0F;
  endfunction
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_fetch(input logic [15:0] a);
    int k;
    k = 0;
    while (!(rd === 1'b1 && addr === a) && k < 500) begin
      @(negedge clk_i);
      k++;
    end
    `CHK("fetch", 1'b1, k < 500)
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      end_of_test();
    end
  end
  always @(negedge clk_i) if (!srst_i) ce_i <= ($urandom % 4) != 0;
  // A write-back of the unchanged byte would leave memory intact, so count strobes.
  always @(negedge clk_i) if (wr === 1'b1 && addr === 16'h0041) tst_wr_cnt++;
  initial begin
    void'($urandom(32'h31fd));
    ra = 8'($urandom);
    b42 = 8'($urandom) & 8'hF7;
    rx = 8'hFF;
    // Bit operations aim only at plain RAM bytes, never write-only ones.
    prog = '{8'hAE, rx, 8'hA6, ra, 8'hB7, 8'h40, 8'hF7, 8'hE7, 8'hFF,
             8'hD7, 8'h07, 8'hF0, 8'hC7, 8'h05, 8'h55, 8'h7C, 8'h6C, 8'hFF, 8'hC3,
             8'h05, 8'h55, 8'h3C, 8'h40, 8'h3D, 8'h41,
             8'h16, 8'h42, 8'h06, 8'h42, 8'h02, 8'hA6, 8'hEE, 8'h07, 8'h42, 8'h02,
             8'hA6, 8'h77, 8'hA9, 8'h09, 8'h20, 8'hFE};
    foreach (prog[i]) u_mem.mem[11'h600 + i] = prog[i];
    u_mem.mem[11'h041] = 8'h80;
    u_mem.mem[11'h042] = b42;
    repeat (6) @(negedge clk_i);
    srst_i = 1'b0;
    wait_fetch(16'h0627);
    repeat (5) @(negedge clk_i);
    wait_fetch(16'h0627);
    s = {1'b0, 8'h77} + 9'h009 + 9'h001;
    `CHK("dir", ra + 8'h01, u_mem.mem[11'h040])
    `CHK("ix", ra + 8'h01, u_mem.mem[{3'h0, rx}])
    `CHK("ix1", ra + 8'h01, u_mem.mem[{3'h0, rx} + 11'h0FF])
    `CHK("ix2", ra, u_mem.mem[ix2_ea(rx, 16'h07F0)])
    `CHK("ext", ra, u_mem.mem[11'h555])
    `CHK("tst", 8'h80, u_mem.mem[11'h041])
    `CHK("tst_wr", 0, tst_wr_cnt)
    `CHK("pc", 16'h0628, pc)
    `CHK("single_bit_set_op", b42 | 8'h08, u_mem.mem[11'h042])
    `CHK("acc", s[7:0], acc)
    `CHK("idx", rx, idx)
    `CHK("ccr", {3'b111, half_c(8'h77, 8'h09, 1'b1), 1'b1, s[7], s[7:0] == 8'h00, s[8]},
      ccr)
    `CHK("mode", M_REL, mode)
    end_of_test();
  end
endmodule
`default_nettype wire
